// [shared/wbdp_pkg.sv]
// Shared constants, types and helpers of the white balance and dither pipeline
package wbdp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFS = 8'h2A;
  localparam logic [7:0] DCTRL_OFFS = 8'h2B;
  localparam logic [7:0] ADDR_OFFS = 8'h2C;
  localparam logic [7:0] PAGE_EXIT_OFFS = 8'hFF;
  localparam logic [7:0] PAGE_RED_VAL = 8'h70;
  localparam logic [7:0] PAGE_GREEN_VAL = 8'hB0;
  localparam logic [7:0] PAGE_BLUE_VAL = 8'hF0;
  localparam logic [7:0] WB_ON_VAL = 8'h20;
  localparam int WB_EN_BIT = 5;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DCTRL_RST = 8'h00;
  localparam int DC_PRE_BIT = 0;
  localparam int DC_POST_BIT = 1;
  localparam int DC_DEONLY_BIT = 2;
  localparam int DC_HSPOL_BIT = 3;
  localparam int DC_VSPOL_BIT = 4;
  localparam int DC_DEPOL_BIT = 5;

  // ----------------------------------------------------------------
  // Strap addresses and timing
  // ----------------------------------------------------------------
  localparam logic [6:0] STRAP_BASE_ADDR = 7'h2C;
  localparam logic [6:0] STRAP_TOP_ADDR = 7'h3C;
  localparam int unsigned VBLANK_CYCLES = 1024;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } wbdp_pix_t;

  typedef struct packed {
    logic horizontal_sync;
    logic vertical_sync;
    logic data_valid_window;
  } wbdp_sync_t;

  typedef struct packed {
    logic [1:0] frame;
    logic [1:0] line;
    logic [2:0] px;
  } wbdp_pos_t;

  typedef struct packed {
    wbdp_pix_t pix;
    wbdp_sync_t sync;
    wbdp_pos_t pos;
  } wbdp_beat_t;

  typedef enum logic [1:0] {PG_MAIN, PG_RED, PG_GREEN, PG_BLUE} wbdp_page_t;

  // Strap code 0..6 step by two from the base, code 7 takes the top address
  function automatic logic [6:0] wbdp_strap_addr(input logic [2:0] code);
    if (code == 3'h7)
    begin
      return STRAP_TOP_ADDR;
    end
    return STRAP_BASE_ADDR + {3'h0, code, 1'b0};
  endfunction

endpackage

// [hdl/wbdp_lut.sv]
// Three colour lookup tables with register port and pixel mapping stage
`timescale 1ns/1ps
module wbdp_lut #(
  parameter int DEPTH = 256
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic wr_en_in,
  input wire wbdp_pkg::wbdp_page_t sel_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rd_data_out,
  input wire logic wb_en_in,
  input wire wbdp_pkg::wbdp_beat_t beat_in,
  output wbdp_pkg::wbdp_beat_t beat_out
);

  logic [7:0] red_mem [DEPTH];
  logic [7:0] green_mem [DEPTH];
  logic [7:0] blue_mem [DEPTH];
  wbdp_pkg::wbdp_beat_t beat_r;
  wbdp_pkg::wbdp_beat_t beat_nxt;

  // Entry N holds the mapping of gray level N
  always_ff @(posedge sys_clk_in)
  begin
    if (wr_en_in && sel_in == wbdp_pkg::PG_RED)
    begin
      red_mem[addr_in] <= wdata_in;
    end
    if (wr_en_in && sel_in == wbdp_pkg::PG_GREEN)
    begin
      green_mem[addr_in] <= wdata_in;
    end
    if (wr_en_in && sel_in == wbdp_pkg::PG_BLUE)
    begin
      blue_mem[addr_in] <= wdata_in;
    end
  end

  always_comb
  begin
    case (sel_in)
      wbdp_pkg::PG_RED: rd_data_out = red_mem[addr_in];
      wbdp_pkg::PG_GREEN: rd_data_out = green_mem[addr_in];
      wbdp_pkg::PG_BLUE: rd_data_out = blue_mem[addr_in];
      default: rd_data_out = 8'h00;
    endcase
  end

  always_comb
  begin
    beat_nxt = beat_in;
    if (wb_en_in)
    begin
      beat_nxt.pix.r = red_mem[beat_in.pix.r];
      beat_nxt.pix.g = green_mem[beat_in.pix.g];
      beat_nxt.pix.b = blue_mem[beat_in.pix.b];
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      beat_r <= '0;
    end
    else
    begin
      beat_r <= beat_nxt;
    end
  end

  assign beat_out = beat_r;

endmodule

// [hdl/wbdp_dither.sv]
// One adaptive temporal and spatial dither stage, 8 to 6 bits per colour
`timescale 1ns/1ps
module wbdp_dither (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic en_in,
  input wire wbdp_pkg::wbdp_beat_t beat_in,
  output wbdp_pkg::wbdp_beat_t beat_out
);

  wbdp_pkg::wbdp_beat_t beat_r;
  wbdp_pkg::wbdp_beat_t beat_nxt;
  logic black;
  logic white;

  // Pattern threshold that cycles over frame, line and pixel
  function automatic logic [2:0] rank(input wbdp_pkg::wbdp_pos_t p, input logic [2:0] ofs);
    return p.px + p.line * 3'd3 + p.frame * 3'd5 + ofs;
  endfunction

  // Default algorithm for one colour
  function automatic logic [7:0] chan(input logic [7:0] v8, input logic [2:0] thr);
    logic [8:0] v9;
    logic [5:0] up;
    v9 = {v8, v8[7]};
    up = v9[8:3];
    if (v8 == 8'h00 || v8 == 8'hFF)
    begin
      return {up, 2'b00};
    end
    if (thr < v9[2:0] && up != 6'h3F)
    begin
      up = up + 6'h01;
    end
    return {up, 2'b00};
  endfunction

  always_comb
  begin
    black = beat_in.pix == '0;
    white = beat_in.pix == '1;
    beat_nxt = beat_in;
    if (en_in)
    begin
      if (black)
      begin
        beat_nxt.pix = '0;
      end
      else if (white)
      begin
        beat_nxt.pix = {3{8'hFC}};
      end
      else
      begin
        beat_nxt.pix.r = chan(beat_in.pix.r, rank(beat_in.pos, 3'd0));
        beat_nxt.pix.g = chan(beat_in.pix.g, rank(beat_in.pos, 3'd2));
        beat_nxt.pix.b = chan(beat_in.pix.b, rank(beat_in.pos, 3'd4));
      end
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      beat_r <= '0;
    end
    else
    begin
      beat_r <= beat_nxt;
    end
  end

  assign beat_out = beat_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  low_bits_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    $past(en_in) |-> beat_r.pix.r[1:0] == 2'b00 && beat_r.pix.g[1:0] == 2'b00
      && beat_r.pix.b[1:0] == 2'b00)
    else $error("dither left low bits active");

  black_hold_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    en_in && beat_in.pix == '0 |=> beat_r.pix == '0)
    else $error("black pixel was dithered");

  stage_bypass_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    !en_in |=> beat_r == $past(beat_in))
    else $error("disabled stage altered pixel");

  frac_zero_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    en_in && beat_in.pix.r[1:0] == 2'b00 && beat_in.pix.r[7] == 1'b0
      && beat_in.pix != '0 |=> beat_r.pix.r == {$past(beat_in.pix.r[7:2]), 2'b00})
    else $error("zero fraction still dithered");

endmodule

// [hdl/wbdp_top.sv]
// Pixel path with pre-table dither, white balance tables and post-table dither
//
// Functional notes
// - Control 0x2A value 0x70 selects red page
// - Value 0xB0 selects green table page
// - Value 0xF0 selects blue table page
// - Value 0x20 enables white balance mapping
// - Page write at N stores entry N
// - Dither turns 8-bit colour into 6-bit
// - Dither mixes temporal and spatial patterns
// - Dithered output low bits held at zero
// - Two dither stages, separate enables
// - First dither stage sits before tables
// - Second dither stage sits after tables
// - Timing mode and polarity drive frame tracking
// - Sub-pixel extended to nine bits first
// - One of four algorithms chosen, default mostly
// - Special algorithms for black, white, full sub-pixels
// - Pattern cell adds one per colour
// - Low three bits pick pattern, 4x4x8 cycle
// - Strap level picks one of eight addresses
// - Each table 256 by 8, read and write
// - Page write to 0xFF returns main page
`timescale 1ns/1ps
module wbdp_top #(
  parameter int unsigned VBLANK_LEN = wbdp_pkg::VBLANK_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic table_page_out,
  input wire logic [2:0] address_strap_pin_in,
  output logic [6:0] dev_addr_out,
  input wire wbdp_pkg::wbdp_pix_t pixel_in,
  input wire wbdp_pkg::wbdp_sync_t sync_in,
  output wbdp_pkg::wbdp_pix_t pixel_out,
  output wbdp_pkg::wbdp_sync_t sync_out
);

  // ----------------------------------------------------------------
  // Register access state
  // ----------------------------------------------------------------
  wbdp_pkg::wbdp_page_t page_r;
  wbdp_pkg::wbdp_page_t page_nxt;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] dctrl_r;
  logic [7:0] dctrl_nxt;
  logic wb_en_r;
  logic wb_en_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] lut_rd_data;
  logic lut_we;
  logic table_page_r;
  logic table_page_nxt;

  always_comb
  begin
    page_nxt = page_r;
    ctrl_nxt = ctrl_r;
    dctrl_nxt = dctrl_r;
    wb_en_nxt = wb_en_r;
    rdata_nxt = rdata_r;
    if (reg_wr_in)
    begin
      if (page_r != wbdp_pkg::PG_MAIN)
      begin
        if (reg_addr_in == wbdp_pkg::PAGE_EXIT_OFFS)
        begin
          page_nxt = wbdp_pkg::PG_MAIN;
        end
      end
      else if (reg_addr_in == wbdp_pkg::CTRL_OFFS)
      begin
        ctrl_nxt = reg_wdata_in;
        if (reg_wdata_in == wbdp_pkg::PAGE_RED_VAL)
        begin
          page_nxt = wbdp_pkg::PG_RED;
        end
        else if (reg_wdata_in == wbdp_pkg::PAGE_GREEN_VAL)
        begin
          page_nxt = wbdp_pkg::PG_GREEN;
        end
        else if (reg_wdata_in == wbdp_pkg::PAGE_BLUE_VAL)
        begin
          page_nxt = wbdp_pkg::PG_BLUE;
        end
        else
        begin
          wb_en_nxt = reg_wdata_in[wbdp_pkg::WB_EN_BIT];
        end
      end
      else if (reg_addr_in == wbdp_pkg::DCTRL_OFFS)
      begin
        dctrl_nxt = reg_wdata_in;
      end
    end
    if (reg_rd_in)
    begin
      if (page_r != wbdp_pkg::PG_MAIN)
      begin
        rdata_nxt = lut_rd_data;
      end
      else if (reg_addr_in == wbdp_pkg::CTRL_OFFS)
      begin
        rdata_nxt = ctrl_r;
      end
      else if (reg_addr_in == wbdp_pkg::DCTRL_OFFS)
      begin
        rdata_nxt = dctrl_r;
      end
      else if (reg_addr_in == wbdp_pkg::ADDR_OFFS)
      begin
        rdata_nxt = {1'b0, dev_addr_out};
      end
      else
      begin
        rdata_nxt = 8'h00;
      end
    end
    table_page_nxt = page_nxt != wbdp_pkg::PG_MAIN;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      page_r <= wbdp_pkg::PG_MAIN;
      ctrl_r <= wbdp_pkg::CTRL_RST;
      dctrl_r <= wbdp_pkg::DCTRL_RST;
      wb_en_r <= 1'b0;
      rdata_r <= 8'h00;
      table_page_r <= 1'b0;
    end
    else
    begin
      page_r <= page_nxt;
      ctrl_r <= ctrl_nxt;
      dctrl_r <= dctrl_nxt;
      wb_en_r <= wb_en_nxt;
      rdata_r <= rdata_nxt;
      table_page_r <= table_page_nxt;
    end
  end

  assign lut_we = reg_wr_in && page_r != wbdp_pkg::PG_MAIN;
  assign reg_rdata_out = rdata_r;
  assign table_page_out = table_page_r;

  // ----------------------------------------------------------------
  // Address strap capture
  // ----------------------------------------------------------------
  logic strap_done_r;
  logic strap_done_nxt;
  logic [6:0] dev_addr_r;
  logic [6:0] dev_addr_nxt;

  always_comb
  begin
    strap_done_nxt = 1'b1;
    dev_addr_nxt = dev_addr_r;
    if (!strap_done_r)
    begin
      dev_addr_nxt = wbdp_pkg::wbdp_strap_addr(address_strap_pin_in);
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      strap_done_r <= 1'b0;
      dev_addr_r <= wbdp_pkg::STRAP_BASE_ADDR;
    end
    else
    begin
      strap_done_r <= strap_done_nxt;
      dev_addr_r <= dev_addr_nxt;
    end
  end

  assign dev_addr_out = dev_addr_r;

  // ----------------------------------------------------------------
  // Frame, line and pixel tracking
  // ----------------------------------------------------------------
  logic hs_act;
  logic vs_act;
  logic de_act;
  logic hs_d_r;
  logic vs_d_r;
  logic de_d_r;
  logic [1:0] frame_r;
  logic [1:0] frame_nxt;
  logic [1:0] line_r;
  logic [1:0] line_nxt;
  logic [2:0] px_r;
  logic [2:0] px_nxt;
  logic [15:0] blank_r;
  logic [15:0] blank_nxt;
  wbdp_pkg::wbdp_beat_t in_beat_r;
  wbdp_pkg::wbdp_beat_t in_beat_nxt;

  always_comb
  begin
    hs_act = sync_in.horizontal_sync ^ dctrl_r[wbdp_pkg::DC_HSPOL_BIT];
    vs_act = sync_in.vertical_sync ^ dctrl_r[wbdp_pkg::DC_VSPOL_BIT];
    de_act = sync_in.data_valid_window ^ dctrl_r[wbdp_pkg::DC_DEPOL_BIT];
    frame_nxt = frame_r;
    line_nxt = line_r;
    px_nxt = de_act ? px_r + 3'd1 : px_r;
    blank_nxt = de_act ? 16'h0000 : (blank_r == 16'hFFFF ? blank_r : blank_r + 16'h0001);
    if (dctrl_r[wbdp_pkg::DC_DEONLY_BIT])
    begin
      if (de_d_r && !de_act)
      begin
        line_nxt = line_r + 2'd1;
        px_nxt = 3'd0;
      end
      if (!de_d_r && de_act && blank_r >= 16'(VBLANK_LEN))
      begin
        frame_nxt = frame_r + 2'd1;
        line_nxt = 2'd0;
      end
    end
    else
    begin
      if (vs_act && !vs_d_r)
      begin
        frame_nxt = frame_r + 2'd1;
        line_nxt = 2'd0;
      end
      else if (hs_act && !hs_d_r)
      begin
        line_nxt = line_r + 2'd1;
      end
      if (hs_act)
      begin
        px_nxt = 3'd0;
      end
    end
    in_beat_nxt.pix = pixel_in;
    in_beat_nxt.sync = sync_in;
    in_beat_nxt.pos = '{frame: frame_nxt, line: line_nxt, px: px_r};
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      hs_d_r <= 1'b0;
      vs_d_r <= 1'b0;
      de_d_r <= 1'b0;
      frame_r <= 2'd0;
      line_r <= 2'd0;
      px_r <= 3'd0;
      blank_r <= 16'h0000;
      in_beat_r <= '0;
    end
    else
    begin
      hs_d_r <= hs_act;
      vs_d_r <= vs_act;
      de_d_r <= de_act;
      frame_r <= frame_nxt;
      line_r <= line_nxt;
      px_r <= px_nxt;
      blank_r <= blank_nxt;
      in_beat_r <= in_beat_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Pixel pipeline
  // ----------------------------------------------------------------
  wbdp_pkg::wbdp_beat_t pre_beat;
  wbdp_pkg::wbdp_beat_t lut_beat;
  wbdp_pkg::wbdp_beat_t post_beat;
  wbdp_pkg::wbdp_pix_t pix_out_r;
  wbdp_pkg::wbdp_sync_t sync_out_r;

  // Pre-table stage for tables calibrated on 6-bit sources
  wbdp_dither u_pre_table_dither (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .en_in(dctrl_r[wbdp_pkg::DC_PRE_BIT]),
    .beat_in(in_beat_r),
    .beat_out(pre_beat)
  );

  wbdp_lut u_lut (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .wr_en_in(lut_we),
    .sel_in(page_r),
    .addr_in(reg_addr_in),
    .wdata_in(reg_wdata_in),
    .rd_data_out(lut_rd_data),
    .wb_en_in(wb_en_r),
    .beat_in(pre_beat),
    .beat_out(lut_beat)
  );

  // Post-table stage reduces the 8-bit table results
  wbdp_dither u_post_table_dither (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .en_in(dctrl_r[wbdp_pkg::DC_POST_BIT]),
    .beat_in(lut_beat),
    .beat_out(post_beat)
  );

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      pix_out_r <= '0;
      sync_out_r <= '0;
    end
    else
    begin
      pix_out_r <= post_beat.pix;
      sync_out_r <= post_beat.sync;
    end
  end

  assign pixel_out = pix_out_r;
  assign sync_out = sync_out_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_tbl_wr;
    reg_wr_in && page_r != wbdp_pkg::PG_MAIN && reg_addr_in != wbdp_pkg::PAGE_EXIT_OFFS;
  endsequence

  sequence s_same_rd;
    reg_rd_in && !reg_wr_in && reg_addr_in == $past(reg_addr_in);
  endsequence

  sequence s_ctrl_wr(logic [7:0] v);
    reg_wr_in && page_r == wbdp_pkg::PG_MAIN && reg_addr_in == wbdp_pkg::CTRL_OFFS
      && reg_wdata_in == v;
  endsequence

  page_red_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    s_ctrl_wr(wbdp_pkg::PAGE_RED_VAL) |=> page_r == wbdp_pkg::PG_RED && table_page_out)
    else $error("red page not selected");

  page_green_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    s_ctrl_wr(wbdp_pkg::PAGE_GREEN_VAL) |=> page_r == wbdp_pkg::PG_GREEN)
    else $error("green page not selected");

  page_blue_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    s_ctrl_wr(wbdp_pkg::PAGE_BLUE_VAL) |=> page_r == wbdp_pkg::PG_BLUE)
    else $error("blue page not selected");

  wb_enable_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    s_ctrl_wr(wbdp_pkg::WB_ON_VAL) |=> wb_en_r && page_r == wbdp_pkg::PG_MAIN)
    else $error("white balance not enabled");

  table_store_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    s_tbl_wr ##1 s_same_rd |=> reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("table entry not stored");

  page_exit_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    reg_wr_in && page_r != wbdp_pkg::PG_MAIN && reg_addr_in == wbdp_pkg::PAGE_EXIT_OFFS
      |=> page_r == wbdp_pkg::PG_MAIN)
    else $error("page exit failed");

  strap_addr_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    $rose(strap_done_r) |-> dev_addr_out == wbdp_pkg::wbdp_strap_addr($past(address_strap_pin_in)))
    else $error("strap address wrong");

  frame_start_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    !dctrl_r[wbdp_pkg::DC_DEONLY_BIT] && vs_act && !vs_d_r |=> line_r == 2'd0)
    else $error("frame start not tracked");

  pass_through_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (!wb_en_r && !dctrl_r[wbdp_pkg::DC_PRE_BIT] && !dctrl_r[wbdp_pkg::DC_POST_BIT])[*6]
      |-> pixel_out == $past(pixel_in, 5))
    else $error("pixel altered with all features off");

endmodule

// [verif/wbdp_panel_model.sv]
// Panel model that latches the processed pixel stream on every clock
`timescale 1ns/1ps
module wbdp_panel_model (
  input wire logic sys_clk_in,
  input wire wbdp_pkg::wbdp_pix_t pixel_in,
  input wire wbdp_pkg::wbdp_sync_t sync_in,
  output wbdp_pkg::wbdp_pix_t shown_out,
  output wbdp_pkg::wbdp_sync_t shown_sync_out
);
  // ----------------------------------------------------------------
  // Capture, as the panel samples each pixel clock
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    shown_out <= pixel_in;
    shown_sync_out <= sync_in;
  end
endmodule

// [verif/wbdp_top_bench.sv]
// Self-checking bench for the white balance and dither pipeline
`timescale 1ns/1ps
module wbdp_top_bench;
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic table_page;
  logic [2:0] strap = 3'h0;
  logic [6:0] dev_addr;
  wbdp_pkg::wbdp_pix_t pix = 24'h000000;
  wbdp_pkg::wbdp_sync_t sync = 3'h1;
  wbdp_pkg::wbdp_pix_t pix_out;
  wbdp_pkg::wbdp_sync_t sync_out;
  wbdp_pkg::wbdp_pix_t shown;
  int n_fail = 0;
  int checked = 0;

  wbdp_top #(.VBLANK_LEN(16)) wbdp_top_i (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_rdata_out(reg_rdata), .table_page_out(table_page), .address_strap_pin_in(strap),
    .dev_addr_out(dev_addr), .pixel_in(pix), .sync_in(sync), .pixel_out(pix_out),
    .sync_out(sync_out));
  wbdp_panel_model wbdp_panel_model_i (.sys_clk_in(sys_clk_in), .pixel_in(pix_out),
    .sync_in(sync_out), .shown_out(shown), .shown_sync_out());

  initial
  begin
    forever #50 sys_clk_in = ~sys_clk_in;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    step(1);
    reg_wr = 1'b0;
    step(1);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_rd = 1'b1;
    reg_addr = a;
    step(1);
    reg_rd = 1'b0;
    d = reg_rdata;
    step(1);
  endtask

  // Table write followed at once by a read of the same entry
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    step(1);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    step(1);
    reg_rd = 1'b0;
    q = reg_rdata;
    step(1);
  endtask

  function automatic logic [7:0] lut_val(input int pg, input logic [7:0] n);
    if (pg == 0)
      return ~n;
    if (pg == 1)
      return n ^ 8'h0F;
    return n + 8'h10;
  endfunction

  task automatic close_out();
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_strap();
    logic [7:0] d;
    for (int c = 0; c < 8; c++)
    begin
      strap = 3'(c);
      sys_rst_in = 1'b1;
      step(3);
      sys_rst_in = 1'b0;
      step(2);
      chk("dev_addr", 24'(dev_addr), (c == 7) ? 24'h3C : 24'(8'h2C + 2 * c));
    end
    rd(8'h2A, d);
    chk("ctrl reset", 24'(d), 24'h0);
    rd(8'h2B, d);
    chk("dither ctrl reset", 24'(d), 24'h0);
    rd(8'h40, d);
    chk("unmapped read", 24'(d), 24'h0);
  endtask

  task automatic t_tables();
    logic [7:0] pg[3] = '{8'h70, 8'hB0, 8'hF0};
    logic [7:0] d;
    for (int p = 0; p < 3; p++)
    begin
      wr(8'h2A, pg[p]);
      chk("page on", 24'(table_page), 24'h1);
      for (int n = 0; n < 255; n++)
        wr(8'(n), lut_val(p, 8'(n)));
      foreach (pg[k])
      begin
        rd(pg[k] + 8'h0E, d);
        chk("entry", 24'(d), 24'(lut_val(p, pg[k] + 8'h0E)));
      end
      wr_rd(8'h3A, lut_val(p, 8'h3A), d);
      chk("write then read", 24'(d), 24'(lut_val(p, 8'h3A)));
      wr(8'hFF, lut_val(p, 8'hFF));
      chk("page off", 24'(table_page), 24'h0);
    end
    wr(8'h2A, 8'h70);
    rd(8'hFF, d);
    chk("last entry", 24'(d), 24'(lut_val(0, 8'hFF)));
    wr(8'hFF, lut_val(0, 8'hFF));
  endtask

  task automatic t_wb();
    logic [7:0] d;
    pix = 24'h123456;
    step(8);
    chk("pass through", shown, 24'h123456);
    wr(8'h2A, 8'h20);
    rd(8'h2A, d);
    chk("ctrl readback", 24'(d), 24'h20);
    step(8);
    chk("mapped", shown, {lut_val(0, 8'h12), lut_val(1, 8'h34), lut_val(2, 8'h56)});
    pix = 24'h81_42_C7;
    for (int s = 0; s < 2; s++)
    begin
      wr(8'h2B, (s == 0) ? 8'h01 : 8'h02);
      step(8);
      for (int i = 0; i < 8; i++)
      begin
        chk("stage order", 24'(shown.r), (shown.r === ((s == 0) ? 8'h7B : 8'h80)) ?
          24'(shown.r) : ((s == 0) ? 24'h7F : 24'h7C));
        step(1);
      end
    end
    wr(8'h2A, 8'h00);
    wr(8'h2B, 8'h00);
  endtask

  task automatic t_dither(input logic [7:0] dctrl, input logic de);
    logic [23:0] src = 24'h81_42_C7;
    logic [7:0] v;
    logic [1:0] lows = 2'h0;
    logic [2:0] idle;
    int adds[3] = '{0, 0, 0};
    int stray = 0;
    int o;
    idle = {dctrl[3], dctrl[4], de};
    wr(8'h2B, dctrl);
    pix = src;
    // Start a new frame and line in the mode under test before measuring
    if (dctrl[2])
    begin
      sync = {idle[2:1], ~de};
      step(20);
    end
    else
    begin
      sync = idle ^ 3'h2;
      step(1);
      sync = idle ^ 3'h4;
      step(1);
    end
    sync = idle;
    step(8);
    chk("sync follow", 24'(sync_out), 24'(idle));
    for (int i = 0; i < 8; i++)
    begin
      for (int c = 0; c < 3; c++)
      begin
        o = 16 - 8 * c;
        v = shown[o +: 8];
        lows = lows | v[1:0];
        if (v[7:2] === src[o + 2 +: 6] + 6'h01)
          adds[c]++;
        else if (v[7:2] !== src[o + 2 +: 6])
          stray++;
      end
      step(1);
    end
    chk("dither low bits", 24'(lows), 24'h0);
    if (dctrl[1:0] != 2'h3)
    begin
      chk("dither stray", 24'(stray), 24'h0);
      for (int c = 0; c < 3; c++)
      begin
        o = 16 - 8 * c;
        chk("density", 24'(adds[c]), 24'({src[o +: 2], src[o + 7]}));
      end
    end
    sync = 3'h1;
  endtask

  task automatic t_special();
    logic [23:0] ins[3] = '{24'h000000, 24'hFFFFFF, 24'h00FF00};
    logic [23:0] outs[3] = '{24'h000000, 24'hFCFCFC, 24'h00FC00};
    wr(8'h2B, 8'h01);
    foreach (ins[k])
    begin
      pix = ins[k];
      step(8);
      chk("special pixel", shown, outs[k]);
    end
  endtask

  initial
  begin
    repeat (20000) @(posedge sys_clk_in);
    n_fail++;
    $display("BAD watchdog expired");
    close_out();
  end

  initial
  begin
    logic [7:0] dc[7] = '{8'h01, 8'h02, 8'h05, 8'h21, 8'h22, 8'h03, 8'h19};
    logic dv[7] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    t_strap();
    t_tables();
    t_wb();
    foreach (dc[k])
      t_dither(dc[k], dv[k]);
    t_special();
    close_out();
  end
endmodule
